/* include/cdmx_pkg.sv */
// constants, register layout and carriers for the disc status output pin mux
// Function
// R1 - after reset the four shared pins are port outputs driving low.
// R2 - writing zero to all four port bits switches all four pins to disc control outputs.
// R3 - writing ones to all four port bits with the io select bit set picks each pin's function from the segment bits.
// R4 - in control mode the speed pin is high at normal speed and low at double speed.
// R5 - in control mode the status clock pin runs at 176.4 kHz.
// R6 - in control mode the status data pin shifts out the processor status word, read with the status clock.
// R7 - in control mode the frame clock pin runs at 7.35 kHz.
// R8 - on subcode block sync detection the sync output goes high at the first sync symbol.
// R9 - the subcode CRC output goes high when the Q channel CRC check passes.
// R10 - firmware sets the power-off bit whenever the disc section supply is removed.
// R11 - with the power-off bit set, every control pin returns to plain port output.
// R12 - the run-length output, enabled by a command bit, drives high when long, low when short, floats in range.
// R13 - control mode holds until software rewrites the port bits or sets the power-off bit.
package cdmx_pkg;

    localparam int CLK_HZ             = 100_000_000;
    localparam int STATUS_CLK_HZ      = 176_400;
    localparam int FRAME_CLK_HZ       = 7_350;
    localparam int STATUS_HALF_CYCLES = CLK_HZ / (2 * STATUS_CLK_HZ);
    localparam int FRAME_HALF_CYCLES  = CLK_HZ / (2 * FRAME_CLK_HZ);

    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STAT     = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;

    localparam int CTRL_W         = 9;
    localparam int CTRL_PORT_LSB  = 0;
    localparam int CTRL_IO_SEL    = 4;
    localparam int CTRL_POWER_OFF = 5;
    localparam int CTRL_RL_SEL    = 6;
    localparam int CTRL_SEG_A     = 7;
    localparam int CTRL_SEG_B     = 8;
    localparam logic [8:0] CTRL_RESET = 9'h000;

    localparam int IRQ_W        = 3;
    localparam int IRQ_SYNC     = 0;
    localparam int IRQ_CRC_OK   = 1;
    localparam int IRQ_CRC_FAIL = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    localparam int STATUS_WORD_W = 16;

    typedef enum logic [1:0] {
        CDMX_PORT,
        CDMX_CTRL_ALL,
        CDMX_CTRL_SEG
    } cdmx_mode_t;

    typedef struct packed {
        logic        double_speed;
        logic [15:0] status_word;
        logic        sync_pulse;
        logic        crc_valid;
        logic        crc_ok;
        logic        run_long;
        logic        run_short;
    } cdmx_core_t;

endpackage

/* hw/cdmx_pin_mux.sv */
// shared output port / disc control pin mux with apb registers
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module cdmx_pin_mux
    import cdmx_pkg::*;
#(
    parameter int FRAME_HALF = FRAME_HALF_CYCLES
)
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire cdmx_core_t  core_i,
    output logic      [3:0]  shared_output_port_bits_o,
    output logic             subcode_block_sync_out_o,
    output logic             subcode_crc_pass_out_o,
    output logic             run_length_max_detect_out_o,
    output logic             run_length_max_detect_oe_o,
    output logic             irq_o
);

    // ------------------------------------------------------------
    // register bus decode
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    cdmx_mode_t        mode;
    cdmx_mode_t        next_mode;

    wire logic apb_setup  = psel_i && !penable_i;
    wire logic apb_done   = psel_i && penable_i && pready_o;
    wire logic apb_wr     = apb_done && pwrite_i;
    wire logic apb_rd     = apb_done && !pwrite_i;
    wire logic hit_ctrl   = paddr_i == OFS_CTRL;
    wire logic hit_stat   = paddr_i == OFS_STAT;
    wire logic hit_istat  = paddr_i == OFS_IRQ_STAT;
    wire logic hit_imask  = paddr_i == OFS_IRQ_MASK;
    wire logic hit_any    = hit_ctrl || hit_stat || hit_istat || hit_imask;
    wire logic wr_ctrl    = apb_wr && hit_ctrl;

    wire logic [3:0] port_bits  = ctrl[CTRL_PORT_LSB +: 4];
    wire logic       power_off  = ctrl[CTRL_POWER_OFF];
    wire logic       rl_sel     = ctrl[CTRL_RL_SEL];
    wire logic       seg_a      = ctrl[CTRL_SEG_A];
    wire logic       seg_b      = ctrl[CTRL_SEG_B];
    wire logic [3:0] wr_port    = pwdata_i[CTRL_PORT_LSB +: 4];

    // ------------------------------------------------------------
    // pin function mode
    // ------------------------------------------------------------
    // mode only moves on a ctrl write, so reset value 0 in the port bits does not
    // by itself mean control mode
    always_comb
    begin
        next_mode = mode;
        if (wr_ctrl)
        begin
            if (pwdata_i[CTRL_POWER_OFF])
                next_mode = CDMX_PORT;                              // R11
            else if (wr_port == 4'h0)
                next_mode = CDMX_CTRL_ALL;                          // R2
            else if (wr_port == 4'hf && pwdata_i[CTRL_IO_SEL])
                next_mode = CDMX_CTRL_SEG;                          // R3
            else
                next_mode = CDMX_PORT;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode <= CDMX_PORT;                                      // R1
            ctrl <= CTRL_RESET;
            irq_mask <= IRQ_RESET;
        end
        else
        begin
            mode <= next_mode;                                      // R13
            if (wr_ctrl)
                ctrl <= pwdata_i[CTRL_W-1:0];
            if (apb_wr && hit_imask)
                irq_mask <= pwdata_i[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // status clock and frame clock dividers
    // ------------------------------------------------------------
    logic [8:0]  st_cnt;
    logic [12:0] fr_cnt;
    logic        status_read_clock;
    logic        correction_frame_clock;
    logic [STATUS_WORD_W-1:0] st_shift;
    logic [3:0]  st_bit;

    wire logic st_wrap  = st_cnt == 9'(STATUS_HALF_CYCLES - 1);
    wire logic fr_wrap  = fr_cnt == 13'(FRAME_HALF - 1);
    // data changes on the falling clock edge so the reader samples on the rise
    wire logic st_shift_en = st_wrap && status_read_clock;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_cnt <= 9'h000;
            status_read_clock <= 1'b0;
        end
        else
        begin
            st_cnt <= st_wrap ? 9'h000 : st_cnt + 9'h001;
            if (st_wrap)
                status_read_clock <= !status_read_clock;            // R5
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fr_cnt <= 13'h0000;
            correction_frame_clock <= 1'b0;
        end
        else
        begin
            fr_cnt <= fr_wrap ? 13'h0000 : fr_cnt + 13'h0001;
            if (fr_wrap)
                correction_frame_clock <= !correction_frame_clock;  // R7
        end
    end

    // status word is captured whole so a changing core word never tears mid-frame
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_shift <= '0;
            st_bit <= 4'h0;
        end
        else if (st_shift_en)
        begin
            st_bit <= st_bit + 4'h1;
            if (st_bit == 4'hf)
                st_shift <= core_i.status_word;                     // R6
            else
                st_shift <= {st_shift[STATUS_WORD_W-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // shared pin selection
    // ------------------------------------------------------------
    wire logic speed_mode_out        = !core_i.double_speed;       // R4
    wire logic status_serial_out     = st_shift[STATUS_WORD_W-1];
    wire logic alt_status_read_clock = !status_read_clock;
    wire logic [3:0] ctrl_func = {correction_frame_clock, status_serial_out,
                                  status_read_clock, speed_mode_out};
    wire logic [3:0] seg_func  = {seg_b ? correction_frame_clock : port_bits[3],
                                  seg_b ? status_serial_out : port_bits[2],
                                  seg_a ? (seg_b ? alt_status_read_clock : status_read_clock) : port_bits[1],
                                  seg_a ? speed_mode_out : port_bits[0]};
    logic [3:0] next_pins;

    always_comb
    begin
        next_pins = port_bits;
        if (!power_off)                                             // R11
        begin
            case (mode)
                CDMX_CTRL_ALL: next_pins = ctrl_func;               // R2
                CDMX_CTRL_SEG: next_pins = seg_func;                // R3
                default:       next_pins = port_bits;
            endcase
        end
    end

    // ------------------------------------------------------------
    // subcode, run length and interrupt outputs
    // ------------------------------------------------------------
    wire logic crc_pass_ev = core_i.crc_valid && core_i.crc_ok;
    wire logic crc_fail_ev = core_i.crc_valid && !core_i.crc_ok;
    wire logic [IRQ_W-1:0] irq_ev = {crc_fail_ev, crc_pass_ev, core_i.sync_pulse};
    wire logic rd_istat = apb_rd && hit_istat;
    // a read clears, but a same-cycle event still lands
    wire logic [IRQ_W-1:0] next_irq_stat = (rd_istat ? IRQ_RESET : irq_stat) | irq_ev;
    wire logic rl_drive = rl_sel && (core_i.run_long || core_i.run_short);

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            shared_output_port_bits_o <= 4'h0;                      // R1
            subcode_block_sync_out_o <= 1'b0;
            subcode_crc_pass_out_o <= 1'b0;
            run_length_max_detect_out_o <= 1'b0;
            run_length_max_detect_oe_o <= 1'b0;
            irq_stat <= IRQ_RESET;
            irq_o <= 1'b0;
        end
        else
        begin
            shared_output_port_bits_o <= next_pins;
            subcode_block_sync_out_o <= core_i.sync_pulse;          // R8
            if (core_i.crc_valid)
                subcode_crc_pass_out_o <= core_i.crc_ok;            // R9
            run_length_max_detect_out_o <= core_i.run_long;         // R12
            run_length_max_detect_oe_o <= rl_drive;                 // R12
            irq_stat <= next_irq_stat;
            irq_o <= |(next_irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    wire logic [31:0] stat_word = {24'h000000, speed_mode_out, subcode_crc_pass_out_o,
                                   shared_output_port_bits_o, mode};
    wire logic [31:0] rd_word = hit_ctrl  ? {23'h000000, ctrl} :
                                hit_stat  ? stat_word :
                                hit_istat ? {29'h00000000, irq_stat} :
                                hit_imask ? {29'h00000000, irq_mask} : 32'h00000000;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
        end
        else
        begin
            pready_o <= apb_setup;
            pslverr_o <= apb_setup && !hit_any;
            if (apb_setup && !pwrite_i)
                prdata_o <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_reset_low;
        @(posedge ref_clk_i) disable iff (rst_i)
        $past(rst_i) |-> shared_output_port_bits_o == 4'h0;
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("pins not low port after reset"); // R1

    property p_zero_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        (wr_ctrl && wr_port == 4'h0 && !pwdata_i[CTRL_POWER_OFF]) |=> mode == CDMX_CTRL_ALL ##1
            shared_output_port_bits_o[1] == $past(status_read_clock);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write did not enter control mode"); // R2

    property p_seg_write;
        @(posedge ref_clk_i) disable iff (rst_i)
        (wr_ctrl && wr_port == 4'hf && pwdata_i[CTRL_IO_SEL] && !pwdata_i[CTRL_POWER_OFF])
            |=> mode == CDMX_CTRL_SEG;
    endproperty
    a_seg_write: assert property (p_seg_write) else $error("segment mode not entered"); // R3

    property p_speed;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode == CDMX_CTRL_ALL && !power_off) |=> shared_output_port_bits_o[0] == !$past(core_i.double_speed);
    endproperty
    a_speed: assert property (p_speed) else $error("speed pin wrong level"); // R4

    property p_status_clk;
        @(posedge ref_clk_i) disable iff (rst_i)
        $changed(status_read_clock) |-> $past(st_cnt) == 9'(STATUS_HALF_CYCLES - 1);
    endproperty
    a_status_clk: assert property (p_status_clk) else $error("status clock half period wrong"); // R5

    property p_status_data;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode == CDMX_CTRL_ALL && !power_off) |=> shared_output_port_bits_o[2] == $past(st_shift[STATUS_WORD_W-1]);
    endproperty
    a_status_data: assert property (p_status_data) else $error("status data pin wrong"); // R6

    property p_frame_clk;
        @(posedge ref_clk_i) disable iff (rst_i)
        $changed(correction_frame_clock) |-> $past(fr_cnt) == 13'(FRAME_HALF - 1);
    endproperty
    a_frame_clk: assert property (p_frame_clk) else $error("frame clock half period wrong"); // R7

    property p_sync;
        @(posedge ref_clk_i) disable iff (rst_i)
        core_i.sync_pulse |=> subcode_block_sync_out_o ##1 (subcode_block_sync_out_o == $past(core_i.sync_pulse));
    endproperty
    a_sync: assert property (p_sync) else $error("block sync not shown"); // R8

    property p_crc;
        @(posedge ref_clk_i) disable iff (rst_i)
        core_i.crc_valid |=> subcode_crc_pass_out_o == $past(core_i.crc_ok);
    endproperty
    a_crc: assert property (p_crc) else $error("crc result output wrong"); // R9

    property p_power_off;
        @(posedge ref_clk_i) disable iff (rst_i)
        power_off |=> shared_output_port_bits_o == $past(port_bits);
    endproperty
    a_power_off: assert property (p_power_off) else $error("power off did not force port"); // R11

    // each implication is bracketed on its own, an unbracketed and would nest them
    property p_run_length;
        @(posedge ref_clk_i) disable iff (rst_i)
        ((rl_sel && !core_i.run_long && !core_i.run_short) |=> !run_length_max_detect_oe_o)
        and ((rl_sel && core_i.run_long)
            |=> (run_length_max_detect_oe_o && run_length_max_detect_out_o));
    endproperty
    a_run_length: assert property (p_run_length) else $error("run length output wrong"); // R12

    property p_run_short;
        @(posedge ref_clk_i) disable iff (rst_i)
        (rl_sel && core_i.run_short) |=> (run_length_max_detect_oe_o && !run_length_max_detect_out_o);
    endproperty
    a_run_short: assert property (p_run_short) else $error("short run not driven low"); // R12

    property p_seg_port;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode == CDMX_CTRL_SEG && !power_off && !seg_a) |=> shared_output_port_bits_o[1:0] == $past(port_bits[1:0]);
    endproperty
    a_seg_port: assert property (p_seg_port) else $error("unselected segment pins not port"); // R3

    property p_frame_pin;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode == CDMX_CTRL_ALL && !power_off) |=> shared_output_port_bits_o[3] == $past(correction_frame_clock);
    endproperty
    a_frame_pin: assert property (p_frame_pin) else $error("frame clock pin wrong"); // R7

    property p_power_mode;
        @(posedge ref_clk_i) disable iff (rst_i)
        (wr_ctrl && pwdata_i[CTRL_POWER_OFF]) |=> mode == CDMX_PORT;
    endproperty
    a_power_mode: assert property (p_power_mode) else $error("power off write left control mode"); // R11

    property p_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode == CDMX_CTRL_ALL && !wr_ctrl) |=> mode == CDMX_CTRL_ALL;
    endproperty
    a_hold: assert property (p_hold) else $error("control mode dropped without write"); // R13

endmodule

/* tb/cdmx_status_reader.sv */
// far-side reader of the status clock, status data and frame clock pins
`timescale 1ns/100ps
module cdmx_status_reader
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  pins_i,
    output logic      [15:0] status_shift_o,
    output logic      [15:0] status_half_o,
    output logic      [15:0] frame_half_o
);
    logic [3:0]  pins_d;
    logic [15:0] st_cnt;
    logic [15:0] fr_cnt;
    wire  logic  st_rise = pins_i[1] & ~pins_d[1];
    wire  logic  st_edge = pins_i[1] ^ pins_d[1];
    wire  logic  fr_edge = pins_i[3] ^ pins_d[3];

    // data is sampled on the rising clock edge, midway between shifts
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pins_d         <= 4'h0;
            st_cnt         <= 16'h0000;
            fr_cnt         <= 16'h0000;
            status_shift_o <= 16'h0000;
            status_half_o  <= 16'h0000;
            frame_half_o   <= 16'h0000;
        end
        else
        begin
            pins_d <= pins_i;
            if (st_rise)
                status_shift_o <= {status_shift_o[14:0], pins_i[2]};
            st_cnt <= st_edge ? 16'h0001 : st_cnt + 16'h0001;
            fr_cnt <= fr_edge ? 16'h0001 : fr_cnt + 16'h0001;
            if (st_edge)
                status_half_o <= st_cnt;
            if (fr_edge)
                frame_half_o <= fr_cnt;
        end
    end
endmodule

/* tb/cdmx_pin_mux_tb.sv */
// self-checking bench for the shared port / disc control pin mux
`timescale 1ns/100ps
module cdmx_pin_mux_tb;
    import cdmx_pkg::*;
    // shortened frame count keeps the run short
    localparam int          FR_HALF = 20;
    localparam logic [15:0] WORD    = 16'hc5a3;
    logic        ref_clk = 1'b0;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    cdmx_core_t  core;
    logic [3:0]  pins;
    logic        sync_out;
    logic        crc_out;
    logic        rl_out;
    logic        rl_oe;
    logic        irq;
    logic [15:0] st_shift;
    logic [15:0] st_half;
    logic [15:0] fr_half;
    logic [31:0] rdata;
    logic        err;
    logic        rot_ok;
    int          miscompares = 0;
    int          checks = 0;

    always #5 ref_clk = ~ref_clk;

    cdmx_pin_mux #(.FRAME_HALF(FR_HALF)) cdmx_pin_mux_inst (
        .ref_clk_i(ref_clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .core_i(core),
        .shared_output_port_bits_o(pins), .subcode_block_sync_out_o(sync_out),
        .subcode_crc_pass_out_o(crc_out), .run_length_max_detect_out_o(rl_out),
        .run_length_max_detect_oe_o(rl_oe), .irq_o(irq));

    cdmx_status_reader cdmx_status_reader_inst (
        .ref_clk_i(ref_clk), .rst_i(rst), .pins_i(pins),
        .status_shift_o(st_shift), .status_half_o(st_half), .frame_half_o(fr_half));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until pready is sampled high, released only then
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            miscompares++;
            tally_and_finish;
        end
        else
        begin
            rdata = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rdata & m, exp);
    endtask

    task automatic ev(input logic s, input logic v, input logic ok);
        @(posedge ref_clk);
        core.sync_pulse <= s;
        core.crc_valid  <= v;
        core.crc_ok     <= ok;
        @(posedge ref_clk);
        core.sync_pulse <= 1'b0;
        core.crc_valid  <= 1'b0;
        @(posedge ref_clk);
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        core = '0;
        core.status_word = WORD;
        tick(12);
        rst <= 1'b0;
        tick(1);
        chk("reset pins", 32'(pins), 32'h0);
        rd_chk("reset ctrl", OFS_CTRL, 32'h1ff, 32'h0);
        rd_chk("reset stat", OFS_STAT, 32'hff, 32'h80);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rdata, 32'h0);
        wr(OFS_CTRL, 32'h5);
        tick(3);
        chk("port pins", 32'(pins), 32'h5);
        wr(OFS_IRQ_MASK, 32'h7);
        wr(OFS_CTRL, 32'h0);
        tick(3);
        rd_chk("mode all", OFS_STAT, 32'h3, 32'h1);
        chk("speed normal", 32'(pins[0]), 32'h1);
        core.double_speed <= 1'b1;
        tick(3);
        chk("speed double", 32'(pins[0]), 32'h0);
        // long enough for the reader to see over 32 status clock periods
        tick(20000);
        chk("status half", 32'(st_half), 32'(STATUS_HALF_CYCLES));
        chk("frame half", 32'(fr_half), 32'(FR_HALF));
        rot_ok = 1'b0;
        for (int i = 0; i < 16; i++)
            if (st_shift === ((WORD << i) | (WORD >> (16 - i))))
                rot_ok = 1'b1;
        chk("status data", 32'(rot_ok), 32'h1);
        ev(1'b1, 1'b0, 1'b0);
        chk("sync high", 32'(sync_out), 32'h1);
        tick(1);
        chk("sync low", 32'(sync_out), 32'h0);
        chk("irq set", 32'(irq), 32'h1);
        rd_chk("irq sync", OFS_IRQ_STAT, 32'h7, 32'h1);
        tick(3);
        chk("irq clear", 32'(irq), 32'h0);
        ev(1'b0, 1'b1, 1'b1);
        chk("crc pass", 32'(crc_out), 32'h1);
        rd_chk("irq crc ok", OFS_IRQ_STAT, 32'h7, 32'h2);
        ev(1'b0, 1'b1, 1'b0);
        chk("crc fail", 32'(crc_out), 32'h0);
        rd_chk("irq crc bad", OFS_IRQ_STAT, 32'h7, 32'h4);
        wr(OFS_IRQ_MASK, 32'h0);
        ev(1'b1, 1'b0, 1'b0);
        tick(2);
        chk("irq masked", 32'(irq), 32'h0);
        rd_chk("irq sticky", OFS_IRQ_STAT, 32'h7, 32'h1);
        rd_chk("mode held", OFS_STAT, 32'h3, 32'h1);
        wr(OFS_CTRL, 32'h2a);
        tick(3);
        chk("power off pins", 32'(pins), 32'ha);
        rd_chk("power off mode", OFS_STAT, 32'h3, 32'h0);
        wr(OFS_CTRL, 32'h9f);
        tick(3);
        rd_chk("mode seg", OFS_STAT, 32'h3, 32'h2);
        chk("seg a speed", 32'(pins[0]), 32'h0);
        chk("seg a port", 32'(pins[3:2]), 32'h3);
        wr(OFS_CTRL, 32'h11f);
        tick(3);
        chk("seg b port", 32'(pins[1:0]), 32'h3);
        wr(OFS_CTRL, 32'h45);
        core.run_long <= 1'b1;
        tick(3);
        chk("rl long", {30'h0, rl_oe, rl_out}, 32'h3);
        core.run_long  <= 1'b0;
        core.run_short <= 1'b1;
        tick(3);
        chk("rl short", {30'h0, rl_oe, rl_out}, 32'h2);
        core.run_short <= 1'b0;
        tick(3);
        chk("rl range", 32'(rl_oe), 32'h0);
        wr(OFS_CTRL, 32'h5);
        core.run_long <= 1'b1;
        tick(3);
        chk("rl unselected", 32'(rl_oe), 32'h0);
        tally_and_finish;
    end
endmodule
